// *** verilog/lcr_regs.vh ***
// constants for the lcd controller serial read path
`ifndef LCR_REGS_VH
`define LCR_REGS_VH
`define LCR_ID_CONTROL 7'h38
`define LCR_ID_DISPLAY 7'h39
`define LCR_ADDR_RESET 8'h00
`define LCR_DIR_READ 1'h1
`define LCR_DIR_WRITE 1'h0
`define LCR_BITS_PER_BYTE 4'h8
`define LCR_ACK_SLOT 4'h8
`endif

// *** verilog/lcr_sync.v ***
// two-stage synchroniser with edge detection for serial clock and data
module lcr_sync (
    clock,
    rstn,
    scl_in,
    sda_in,
    scl_s,
    sda_s,
    scl_rise,
    scl_fall,
    start_det,
    stop_det
);
    input clock;
    input rstn;
    input scl_in;
    input sda_in;
    output scl_s;
    output sda_s;
    output scl_rise;
    output scl_fall;
    output start_det;
    output stop_det;
    reg [1:0] scl_reg;
    reg [1:0] sda_reg;
    reg scl_d_reg;
    reg sda_d_reg;
    wire scl_s;
    wire sda_s;
    assign scl_s = scl_reg[1];
    assign sda_s = sda_reg[1];
    always @(posedge clock) begin
        if (!rstn) begin
            scl_reg <= 2'h3;
            sda_reg <= 2'h3;
            scl_d_reg <= 1'h1;
            sda_d_reg <= 1'h1;
        end else begin
            scl_reg <= {scl_reg[0], scl_in};
            sda_reg <= {sda_reg[0], sda_in};
            scl_d_reg <= scl_reg[1];
            sda_d_reg <= sda_reg[1];
        end
    end
    assign scl_rise = scl_s & ~scl_d_reg;
    assign scl_fall = ~scl_s & scl_d_reg;
    // data moving while clock stays high
    assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
endmodule

// *** verilog/lcr_i2c_read.v ***
// serial slave read path of the lcd controller
`include "lcr_regs.vh"
// Operation
// - Answer identifier 0111000 for control block, 0111001 for display block.
// - Id on clocks one to seven, write bit eighth, acknowledge ninth.
// - Eight address bits follow, acknowledged on the ninth clock.
// - Repeated start, same id with read bit, acknowledged ninth clock.
// - After read acknowledge, drive register byte most significant bit first.
// - Register address advances by one after each byte accessed.
// - Reset port bit low resets the controller and its serial interface.
// - Data shifted msb first, changed on falling, captured on rising edge.
module lcr_i2c_read (
    clock,
    rstn,
    lcd_reset_port_bit,
    scl_in,
    sda_in,
    serial_data_pin_out,
    serial_data_pin_oe,
    reg_addr,
    reg_sel_display,
    reg_rdata,
    reg_wr,
    reg_wdata,
    start_condition_marker,
    stop_condition_marker
);
    input clock;
    input rstn;
    input lcd_reset_port_bit;
    input scl_in;
    input sda_in;
    output serial_data_pin_out;
    output serial_data_pin_oe;
    output [7:0] reg_addr;
    output reg_sel_display;
    input [7:0] reg_rdata;
    output reg_wr;
    output [7:0] reg_wdata;
    output start_condition_marker;
    output stop_condition_marker;

    // ****************************************
    // states
    // ****************************************
    localparam PH_IDLE = 3'h0;
    localparam PH_ID = 3'h1;
    localparam PH_ID_ACK = 3'h2;
    localparam PH_ADDR = 3'h3;
    localparam PH_ADDR_ACK = 3'h4;
    localparam PH_TX = 3'h5;
    localparam PH_TX_ACK = 3'h6;
    localparam PH_WDATA = 3'h7;

    reg [2:0] state_reg;
    reg [3:0] bit_cnt_reg;
    reg [7:0] shift_reg;
    reg [7:0] addr_reg;
    reg sel_disp_reg;
    reg dir_read_reg;
    reg [7:0] tx_reg;
    reg drive_low_reg;
    reg wr_reg;
    reg [7:0] wdata_reg;
    reg wack_reg;
    reg start_reg;
    reg stop_reg;
    reg [1:0] prt_reg;
    wire scl_s;
    wire sda_s;
    wire scl_rise;
    wire scl_fall;
    wire start_det;
    wire stop_det;
    wire srst;
    wire [7:0] rx_byte;
    wire id_ctl;
    wire id_disp;

    // ****************************************
    // input synchronisation
    // ****************************************
    lcr_sync lcr_sync_inst (
        .clock(clock),
        .rstn(rstn),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .scl_s(scl_s),
        .sda_s(sda_s),
        .scl_rise(scl_rise),
        .scl_fall(scl_fall),
        .start_det(start_det),
        .stop_det(stop_det)
    );

    always @(posedge clock) begin
        if (!rstn)
            prt_reg <= 2'h3;
        else
            prt_reg <= {prt_reg[0], lcd_reset_port_bit};
    end
    assign srst = ~rstn | ~prt_reg[1];

    assign rx_byte = {shift_reg[6:0], sda_s};
    // identifier match
    // byte already complete in shift_reg at the falling edge
    assign id_ctl = (shift_reg[7:1] == `LCR_ID_CONTROL);
    assign id_disp = (shift_reg[7:1] == `LCR_ID_DISPLAY);

    // ****************************************
    // protocol engine
    // ****************************************
    always @(posedge clock) begin
        if (srst) begin
            state_reg <= PH_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            addr_reg <= `LCR_ADDR_RESET;
            sel_disp_reg <= 1'h0;
            dir_read_reg <= 1'h0;
            tx_reg <= 8'h00;
            drive_low_reg <= 1'h0;
            wr_reg <= 1'h0;
            wdata_reg <= 8'h00;
            wack_reg <= 1'h0;
            start_reg <= 1'h0;
            stop_reg <= 1'h0;
        end else begin
            wr_reg <= 1'h0;
            start_reg <= start_det;
            stop_reg <= stop_det;
            if (stop_det) begin
                state_reg <= PH_IDLE;
                drive_low_reg <= 1'h0;
            end else if (start_det) begin
                state_reg <= PH_ID;
                bit_cnt_reg <= 4'h0;
                drive_low_reg <= 1'h0;
            end else begin
                case (state_reg)
                PH_ID, PH_ADDR, PH_WDATA: begin
                    if (scl_rise) begin
                        shift_reg <= rx_byte;
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                    if (scl_fall && bit_cnt_reg == `LCR_BITS_PER_BYTE) begin
                        bit_cnt_reg <= 4'h0;
                        if (state_reg == PH_ID) begin
                            // id and direction taken, ack if matched
                            if (id_ctl | id_disp) begin
                                drive_low_reg <= 1'h1;
                                sel_disp_reg <= shift_reg[1];
                                dir_read_reg <= shift_reg[0];
                                state_reg <= PH_ID_ACK;
                            end else begin
                                state_reg <= PH_IDLE;
                            end
                        end else begin
                            drive_low_reg <= 1'h1;
                            state_reg <= PH_ADDR_ACK;
                            if (state_reg == PH_ADDR) begin
                                addr_reg <= shift_reg;
                                wack_reg <= 1'h0;
                            end else begin
                                wdata_reg <= shift_reg;
                                wr_reg <= 1'h1;
                                wack_reg <= 1'h1;
                            end
                        end
                    end
                end
                PH_ID_ACK, PH_ADDR_ACK: begin
                    if (scl_fall) begin
                        drive_low_reg <= 1'h0;
                        bit_cnt_reg <= 4'h0;
                        if (state_reg == PH_ADDR_ACK) begin
                            if (wack_reg)
                                addr_reg <= addr_reg + 8'h01;
                            state_reg <= PH_WDATA;
                        end else if (dir_read_reg == `LCR_DIR_READ) begin
                            tx_reg <= reg_rdata;
                            drive_low_reg <= ~reg_rdata[7];
                            state_reg <= PH_TX;
                        end else begin
                            state_reg <= PH_ADDR;
                        end
                    end
                end
                PH_TX: begin
                    if (scl_rise)
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    if (scl_fall) begin
                        if (bit_cnt_reg == `LCR_BITS_PER_BYTE) begin
                            drive_low_reg <= 1'h0;
                            addr_reg <= addr_reg + 8'h01;
                            state_reg <= PH_TX_ACK;
                        end else begin
                            tx_reg <= {tx_reg[6:0], 1'h0};
                            drive_low_reg <= ~tx_reg[6];
                        end
                    end
                end
                PH_TX_ACK: begin
                    // master ack fetches next byte, nak returns to idle
                    if (scl_rise) begin
                        if (!sda_s) begin
                            bit_cnt_reg <= 4'h0;
                            state_reg <= PH_ID_ACK;
                            dir_read_reg <= 1'h1;
                        end else begin
                            state_reg <= PH_IDLE;
                        end
                    end
                end
                default: state_reg <= PH_IDLE;
                endcase
            end
        end
    end

    assign serial_data_pin_out = 1'h0;
    assign serial_data_pin_oe = drive_low_reg;
    assign reg_addr = addr_reg;
    assign reg_sel_display = sel_disp_reg;
    assign reg_wr = wr_reg;
    assign reg_wdata = wdata_reg;
    assign start_condition_marker = start_reg;
    assign stop_condition_marker = stop_reg;
endmodule

// *** tb/lcr_i2c_read_chk.sv ***
// pin assertions for the serial read path
module lcr_i2c_read_chk (
    input wire clock,
    input wire rstn,
    input wire lcd_reset_port_bit,
    input wire scl_in,
    input wire sda_in,
    input wire serial_data_pin_out,
    input wire serial_data_pin_oe,
    input wire [7:0] reg_addr,
    input wire start_condition_marker,
    input wire stop_condition_marker
);
    timeunit 1ns;
    timeprecision 1ns;
    wire oe = serial_data_pin_oe;
    wire prt = lcd_reset_port_bit;
    wire sm = start_condition_marker;
    wire pm = stop_condition_marker;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);
    // ****************
    // pin checks
    // ****************
    a_open_drain: assert property (serial_data_pin_out == 1'b0)
        else $error("data pin driven high");
    a_oe_on_fall: assert property ($changed(oe) && prt && $past(prt, 4) |-> !scl_in)
        else $error("oe moved with clock high");
    a_oe_held_high: assert property ($rose(scl_in) && prt |=> $stable(oe) [*4])
        else $error("oe moved after clock rise");
    a_start_seen: assert property (scl_in && $fell(sda_in) && prt |-> ##[1:5] sm)
        else $error("start not flagged");
    a_stop_seen: assert property (scl_in && $rose(sda_in) && prt |-> ##[1:5] pm)
        else $error("stop not flagged");
    a_start_pulse: assert property (sm |=> !sm)
        else $error("start flag too long");
    a_port_clears: assert property (!prt [*4] |-> !oe && reg_addr == 8'h00)
        else $error("port reset ignored");
    a_stop_quiet: assert property (pm |-> !oe)
        else $error("line held at stop");
    c_start: cover property (sm);
    c_stop: cover property (pm);
    c_drive: cover property ($rose(oe));
endmodule
bind lcr_i2c_read lcr_i2c_read_chk lcr_i2c_read_chk_inst (
    .clock, .rstn, .lcd_reset_port_bit, .scl_in, .sda_in, .serial_data_pin_out,
    .serial_data_pin_oe, .reg_addr, .start_condition_marker, .stop_condition_marker
);

// *** tb/lcr_host_model.sv ***
// host serial master model with open-drain data
module lcr_host_model (
    input wire logic clock,
    input wire logic sda,
    output logic scl,
    output logic sda_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    // ****************
    // bus tasks
    // ****************
    task automatic wq(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic start;
        wq(2);
        sda_oe = 1'b0;
        wq(2);
        scl = 1'b1;
        wq(2);
        sda_oe = 1'b1;
        wq(2);
        scl = 1'b0;
    endtask
    task automatic stop;
        wq(2);
        sda_oe = 1'b1;
        wq(2);
        scl = 1'b1;
        wq(2);
        sda_oe = 1'b0;
        wq(2);
    endtask
    task automatic xbit(input logic b, output logic r);
        wq(1);
        sda_oe = ~b;
        wq(3);
        scl = 1'b1;
        wq(2);
        r = sda;
        wq(2);
        scl = 1'b0;
    endtask
    task automatic xbyte(input logic [7:0] d, input logic ack, output logic [7:0] q,
        output logic got);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(d[i], r);
            q[i] = r;
        end
        xbit(~ack, r);
        got = ~r;
    endtask
endmodule

// *** tb/test_lcr_i2c_read.sv ***
// self-checking bench for the serial read path
module test_lcr_i2c_read;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic prt = 1'b1;
    logic scl, m_oe, oe, sm, pm, sel;
    logic [7:0] addr, rd;
    logic wr;
    logic [7:0] wdata;
    logic [7:0] wlat = 8'h00;
    wire sda = ~(m_oe | oe);
    int n_fail = 0;
    int tests_run = 0;
    logic [31:0] lfsr = 32'hD193;
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [7:0] exp_byte(input logic [7:0] a, input logic s);
        return {a[3:0], a[7:4]} ^ {s, 7'h2A};
    endfunction
    assign rd = exp_byte(addr, sel);
    lcr_i2c_read lcr_i2c_read_inst (.clock, .rstn, .lcd_reset_port_bit(prt), .scl_in(scl),
        .sda_in(sda), .serial_data_pin_out(), .serial_data_pin_oe(oe), .reg_addr(addr),
        .reg_sel_display(sel), .reg_rdata(rd), .reg_wr(wr), .reg_wdata(wdata),
        .start_condition_marker(sm), .stop_condition_marker(pm));
    lcr_host_model lcr_host_model_inst (.clock, .sda, .scl, .sda_oe(m_oe));
    // write strobe capture
    always @(posedge clock) begin
        if (wr)
            wlat <= wdata;
    end
    initial begin
        forever #25 clock = ~clock;
    end
    // ****************
    // tasks
    // ****************
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        tests_run++;
        if (seen !== want) begin
            n_fail++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic do_read(input logic [6:0] id, input logic [7:0] a, input int n);
        logic [7:0] q;
        logic g;
        lcr_host_model_inst.start();
        lcr_host_model_inst.xbyte({id, 1'b0}, 1'b0, q, g);
        check({7'h00, g}, {7'h00, id[6:1] == 6'h1C}); // id answer
        lcr_host_model_inst.xbyte(a, 1'b0, q, g);
        check({7'h00, g}, {7'h00, id[6:1] == 6'h1C}); // address answer
        if (id[6:1] == 6'h1C) begin
            lcr_host_model_inst.start();
            lcr_host_model_inst.xbyte({id, 1'b1}, 1'b0, q, g);
            check({7'h00, g}, 8'h01); // read answer
            for (int i = 0; i < n; i++) begin
                lcr_host_model_inst.xbyte(8'hFF, i < n - 1, q, g);
                check(q, exp_byte(a + i[7:0], id[0])); // bytes
            end
        end
        lcr_host_model_inst.stop();
        $display("read %h %h done", id, a);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ****************
    // sequence
    // ****************
    initial begin
        logic [7:0] q;
        logic g;
        repeat (5) @(negedge clock);
        rstn = 1'b1;
        repeat (4) @(negedge clock);
        check({5'h00, oe, sm, pm}, 8'h00); // idle outputs
        do_read(7'h38, 8'hFF, 2);
        do_read(7'h45, 8'h10, 1);
        for (int t = 0; t < 8; t++) begin
            lfsr = lfsr_next(lfsr);
            do_read({6'h1C, lfsr[0]}, lfsr[15:8], int'(lfsr[5:4]) + 1);
        end
        lcr_host_model_inst.start();
        lcr_host_model_inst.xbyte(8'h72, 1'b0, q, g);
        lcr_host_model_inst.xbyte(8'h40, 1'b0, q, g);
        lcr_host_model_inst.start();
        lcr_host_model_inst.xbyte(8'h73, 1'b0, q, g);
        check({7'h00, oe}, 8'h01); // line held before reset
        prt = 1'b0;
        repeat (6) @(negedge clock);
        check({7'h00, oe}, 8'h00); // line freed
        check(addr, 8'h00); // pointer cleared
        prt = 1'b1;
        repeat (8) @(negedge clock);
        lcr_host_model_inst.stop();
        $display("port reset done");
        do_read(7'h39, 8'h27, 3);
        lcr_host_model_inst.start();
        lcr_host_model_inst.xbyte(8'h70, 1'b0, q, g);
        check({7'h00, g}, 8'h01); // write id answer
        lcr_host_model_inst.xbyte(8'h05, 1'b0, q, g);
        check({7'h00, g}, 8'h01); // address answer
        lcr_host_model_inst.xbyte(8'h5A, 1'b0, q, g);
        lcr_host_model_inst.stop();
        check(wlat, 8'h5A); // write data capture; 5A reads the same msb or lsb first
        check(addr, 8'h06); // advance after write
        $display("write 38 05 done");
        print_verdict;
    end
endmodule
